// File: pkg/bcwm_pkg.sv
// package: constants and types of the block change watch mask
package bcwm_pkg;

    // =========================================================
    // geometry
    // =========================================================
    localparam int BCWM_BLOCKS = 64;
    localparam int BCWM_INDEX_W = 6;
    localparam int BCWM_ADDR_W = 12;
    localparam int BCWM_DATA_W = 32;
    localparam int BCWM_COUNT_W = 16;

    // =========================================================
    // register byte offsets
    // =========================================================
    localparam logic [11:0] BCWM_MASK_LO_OFFSET = 12'h430;
    localparam logic [11:0] BCWM_MASK_HI_OFFSET = 12'h434;
    localparam logic [11:0] BCWM_STATUS_OFFSET = 12'h438;
    localparam logic [11:0] BCWM_HIT_COUNT_OFFSET = 12'h43c;

    // =========================================================
    // status field positions
    // =========================================================
    localparam int BCWM_STATUS_INDEX_LSB = 0;
    localparam int BCWM_STATUS_SEEN_BIT = 8;
    localparam int BCWM_STATUS_MONITOR_BIT = 9;

    // =========================================================
    // reset values and the hit count limit
    // =========================================================
    localparam logic [63:0] BCWM_MASK_RESET = 64'h0;
    localparam logic [15:0] BCWM_COUNT_RESET = 16'h0;
    localparam logic [15:0] BCWM_COUNT_MAX = 16'hffff;

    // =========================================================
    // bus answers
    // =========================================================
    localparam logic [1:0] BCWM_RESP_OKAY = 2'h0;
    localparam logic [1:0] BCWM_RESP_SLVERR = 2'h2;

    // =========================================================
    // state machines
    // =========================================================
    typedef enum logic [1:0] {
        BCWM_WR_IDLE = 2'b01,
        BCWM_WR_RESP = 2'b10
    } bcwm_wr_state_type;

    typedef enum logic [1:0] {
        BCWM_RD_IDLE = 2'b01,
        BCWM_RD_DATA = 2'b10
    } bcwm_rd_state_type;

endpackage : bcwm_pkg

// File: src/bcwm_change_gate.sv
// module: per-block gate of change events by the watch mask
`timescale 1ns/100ps
module bcwm_change_gate
    import bcwm_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [63:0] watch_mask_i,
    input wire logic change_valid_i,
    input wire logic [5:0] change_index_i,
    output logic hit_o,
    output logic [5:0] hit_index_o,
    output logic hit_seen_o
);

    typedef struct packed {
        logic hit;
        logic [5:0] index;
        logic seen;
    } bcwm_gate_state_type;

    bcwm_gate_state_type r_reg;
    bcwm_gate_state_type r_next;

    // =========================================================
    // gate
    // =========================================================
    always_comb begin
        r_next = r_reg;
        if (ce_i) begin
            r_next.hit = 1'b0;
            if (change_valid_i && watch_mask_i[change_index_i]) begin
                r_next.hit = 1'b1;
                r_next.index = change_index_i;
                r_next.seen = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign hit_o = r_reg.hit;
    assign hit_index_o = r_reg.index;
    assign hit_seen_o = r_reg.seen;

endmodule : bcwm_change_gate

// File: src/bcwm_watch_mask.sv
// module: watch mask register bank with an axi4-lite slave
`timescale 1ns/100ps
module bcwm_watch_mask
    import bcwm_pkg::*;
#(
    parameter int ADDR_W = BCWM_ADDR_W
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // axi4-lite write address
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    // axi4-lite write data
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // axi4-lite write response
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // axi4-lite read address
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    // axi4-lite read data
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // shared memory side
    input wire logic memory_monitor_node_i,
    input wire logic change_valid_i,
    input wire logic [5:0] change_index_i,
    output logic [63:0] watch_mask_o,
    output logic watched_change_o,
    output logic [5:0] watched_index_o
);

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic [63:0] mask;
        bcwm_wr_state_type wr_state;
        bcwm_rd_state_type rd_state;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] hit_count;
        logic monitor;
    } bcwm_state_type;

    localparam bcwm_state_type STATE_RESET = '{
        mask: BCWM_MASK_RESET,
        wr_state: BCWM_WR_IDLE,
        rd_state: BCWM_RD_IDLE,
        aw_held: 1'b0,
        aw_addr: '0,
        w_held: 1'b0,
        w_data: '0,
        w_strb: '0,
        awready: 1'b1,
        wready: 1'b1,
        bvalid: 1'b0,
        bresp: BCWM_RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rdata: '0,
        rresp: BCWM_RESP_OKAY,
        hit_count: BCWM_COUNT_RESET,
        monitor: 1'b0
    };

    bcwm_state_type r_reg;
    bcwm_state_type r_next;

    logic gate_hit;
    logic [5:0] gate_index;
    logic gate_seen;

    // =========================================================
    // helpers
    // =========================================================
    // word match on the aligned address; the low two bits are ignored
    function automatic logic addr_is(
        input logic [ADDR_W-1:0] addr,
        input logic [11:0] offset
    );
        logic [11:0] a12;
        a12 = 12'(addr);
        addr_is = (a12[11:2] == offset[11:2]);
    endfunction : addr_is

    // byte lanes of a write onto one 32-bit word
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_word[8*i +: 8];
            end
        end
        merge_strb = res;
    endfunction : merge_strb

    // =========================================================
    // mask gate
    // =========================================================
    // mask selects detection
    bcwm_change_gate u_gate (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .watch_mask_i(r_reg.mask),
        .change_valid_i(change_valid_i),
        .change_index_i(change_index_i),
        .hit_o(gate_hit),
        .hit_index_o(gate_index),
        .hit_seen_o(gate_seen)
    );

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        logic do_write;
        logic count_clear;
        do_write = 1'b0;
        count_clear = 1'b0;
        r_next = r_reg;
        if (ce_i) begin
            // mode is only reported; the gate ignores it on purpose
            r_next.monitor = memory_monitor_node_i;

            // address and data may arrive in either order
            if (s_axi_awvalid_i && r_reg.awready) begin
                r_next.aw_held = 1'b1;
                r_next.aw_addr = s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && r_reg.wready) begin
                r_next.w_held = 1'b1;
                r_next.w_data = s_axi_wdata_i;
                r_next.w_strb = s_axi_wstrb_i;
            end

            case (r_reg.wr_state)
                BCWM_WR_IDLE: begin
                    if (r_next.aw_held && r_next.w_held) begin
                        do_write = 1'b1;
                        r_next.aw_held = 1'b0;
                        r_next.w_held = 1'b0;
                        r_next.bvalid = 1'b1;
                        r_next.wr_state = BCWM_WR_RESP;
                    end
                end
                BCWM_WR_RESP: begin
                    if (s_axi_bready_i) begin
                        r_next.bvalid = 1'b0;
                        r_next.wr_state = BCWM_WR_IDLE;
                    end
                end
                default: begin
                    r_next.wr_state = BCWM_WR_IDLE;
                end
            endcase

            if (do_write) begin
                r_next.bresp = BCWM_RESP_OKAY;
                if (addr_is(r_next.aw_addr, BCWM_MASK_LO_OFFSET)) begin
                    r_next.mask[31:0] = merge_strb(r_reg.mask[31:0],
                        r_next.w_data, r_next.w_strb);
                end else if (addr_is(r_next.aw_addr,
                        BCWM_MASK_HI_OFFSET)) begin
                    r_next.mask[63:32] = merge_strb(r_reg.mask[63:32],
                        r_next.w_data, r_next.w_strb);
                end else if (addr_is(r_next.aw_addr,
                        BCWM_STATUS_OFFSET)) begin
                    // status is read only; writes are dropped silently
                    r_next.bresp = BCWM_RESP_OKAY;
                end else if (addr_is(r_next.aw_addr,
                        BCWM_HIT_COUNT_OFFSET)) begin
                    count_clear = 1'b1;
                end else begin
                    r_next.bresp = BCWM_RESP_SLVERR;
                end
            end

            // one write at a time: no new beats while one is pending
            r_next.awready = (r_next.wr_state == BCWM_WR_IDLE) &&
                !r_next.aw_held;
            r_next.wready = (r_next.wr_state == BCWM_WR_IDLE) &&
                !r_next.w_held;

            case (r_reg.rd_state)
                BCWM_RD_IDLE: begin
                    if (s_axi_arvalid_i) begin
                        r_next.arready = 1'b0;
                        r_next.rvalid = 1'b1;
                        r_next.rresp = BCWM_RESP_OKAY;
                        r_next.rdata = 32'h0;
                        r_next.rd_state = BCWM_RD_DATA;
                        if (addr_is(s_axi_araddr_i,
                                BCWM_MASK_LO_OFFSET)) begin
                            r_next.rdata = r_reg.mask[31:0];
                        end else if (addr_is(s_axi_araddr_i,
                                BCWM_MASK_HI_OFFSET)) begin
                            r_next.rdata = r_reg.mask[63:32];
                        end else if (addr_is(s_axi_araddr_i,
                                BCWM_STATUS_OFFSET)) begin
                            r_next.rdata[BCWM_STATUS_INDEX_LSB +: 6] =
                                gate_index;
                            r_next.rdata[BCWM_STATUS_SEEN_BIT] =
                                gate_seen;
                            r_next.rdata[BCWM_STATUS_MONITOR_BIT] =
                                r_reg.monitor;
                        end else if (addr_is(s_axi_araddr_i,
                                BCWM_HIT_COUNT_OFFSET)) begin
                            r_next.rdata[15:0] = r_reg.hit_count;
                        end else begin
                            r_next.rresp = BCWM_RESP_SLVERR;
                        end
                    end
                end
                BCWM_RD_DATA: begin
                    if (s_axi_rready_i) begin
                        r_next.rvalid = 1'b0;
                        r_next.arready = 1'b1;
                        r_next.rd_state = BCWM_RD_IDLE;
                    end
                end
                default: begin
                    r_next.rd_state = BCWM_RD_IDLE;
                end
            endcase

            // a hit in the clearing cycle still counts: clear wins, the count restarts at 1
            if (count_clear) begin
                r_next.hit_count = gate_hit ? 16'h1 : BCWM_COUNT_RESET;
            end else if (gate_hit &&
                    r_reg.hit_count != BCWM_COUNT_MAX) begin
                r_next.hit_count = r_reg.hit_count + 16'h1;
            end
        end
    end

    // =========================================================
    // registers
    // =========================================================
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            r_reg <= STATE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    assign s_axi_awready_o = r_reg.awready;
    assign s_axi_wready_o = r_reg.wready;
    assign s_axi_bvalid_o = r_reg.bvalid;
    assign s_axi_bresp_o = r_reg.bresp;
    assign s_axi_arready_o = r_reg.arready;
    assign s_axi_rvalid_o = r_reg.rvalid;
    assign s_axi_rdata_o = r_reg.rdata;
    assign s_axi_rresp_o = r_reg.rresp;
    assign watch_mask_o = r_reg.mask;
    assign watched_change_o = gate_hit;
    assign watched_index_o = gate_index;

endmodule : bcwm_watch_mask

// File: verif/bcwm_watch_mask_monitor.sv
// checker: port assertions of the watch mask register bank
`timescale 1ns/100ps
module bcwm_watch_mask_monitor
    import bcwm_pkg::*;
#(
    parameter int ADDR_W = BCWM_ADDR_W
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic change_valid_i,
    input wire logic [5:0] change_index_i,
    input wire logic [63:0] watch_mask_o,
    input wire logic watched_change_o,
    input wire logic [5:0] watched_index_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    // =========================================================
    // assertions
    // =========================================================
    property p_reset_zero;
        $fell(srst_i) |-> watch_mask_o == BCWM_MASK_RESET
            && !s_axi_bvalid_o && !s_axi_rvalid_o;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("mask or answer not clear after reset");
    property p_hit;
        ce_i && change_valid_i && watch_mask_o[change_index_i] |=>
            watched_change_o && watched_index_o == $past(change_index_i);
    endproperty
    a_hit: assert property (p_hit)
        else $error("watched change missing or wrong index");
    property p_miss;
        ce_i && !(change_valid_i && watch_mask_o[change_index_i])
            |=> !watched_change_o;
    endproperty
    a_miss: assert property (p_miss)
        else $error("change reported for an unwatched block");
    // the mask may only move as a write completes
    property p_mask_src;
        $changed(watch_mask_o) |-> $rose(s_axi_bvalid_o);
    endproperty
    a_mask_src: assert property (p_mask_src)
        else $error("mask changed without a write");
    property p_b_after;
        ce_i && s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
            && s_axi_wready_o |=> s_axi_bvalid_o && !s_axi_awready_o;
    endproperty
    a_b_after: assert property (p_b_after)
        else $error("write response late");
    property p_b_hold;
        ce_i && s_axi_bvalid_o && !s_axi_bready_i |=>
            s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_r_hold;
        ce_i && s_axi_rvalid_o && !s_axi_rready_i |=>
            s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    property p_rd_mask;
        ce_i && s_axi_arvalid_i && s_axi_arready_o
            && s_axi_araddr_i[11:3] == 9'h86 |=> s_axi_rvalid_o
            && s_axi_rdata_o == ($past(s_axi_araddr_i[2]) ?
            $past(watch_mask_o[63:32]) : $past(watch_mask_o[31:0]));
    endproperty
    a_rd_mask: assert property (p_rd_mask)
        else $error("mask read does not match the mask");
endmodule : bcwm_watch_mask_monitor

bind bcwm_watch_mask bcwm_watch_mask_monitor #(.ADDR_W(ADDR_W))
    bcwm_watch_mask_monitor_inst (.sys_clk_i, .srst_i, .ce_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i,
    .s_axi_rdata_o, .change_valid_i, .change_index_i, .watch_mask_o,
    .watched_change_o, .watched_index_o);

// File: verif/tb_bcwm_watch_mask.sv
// testbench: register bus and change gate of the watch mask bank
`timescale 1ns/100ps
module tb_bcwm_watch_mask
    import bcwm_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0, change_valid_i = 1'b0;
    logic memory_monitor_node_i = 1'b0;
    logic [11:0] s_axi_awaddr_i = 12'h0, s_axi_araddr_i = 12'h0;
    logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'h0;
    logic [5:0] change_index_i = 6'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, watched_change_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic [63:0] watch_mask_o, m;
    logic [5:0] watched_index_o;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    logic [5:0] exp_h[$];
    logic [33:0] e_r;
    logic [5:0] e_h;
    logic [5:0] last_idx = 6'h0;
    logic seen = 1'b0;
    int n_errors = 0;
    int n_checks = 0;

    bcwm_watch_mask #(.ADDR_W(BCWM_ADDR_W)) bcwm_watch_mask_inst (
        .sys_clk_i, .srst_i, .ce_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_awaddr_i, .s_axi_awprot_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_araddr_i, .s_axi_arprot_i, .s_axi_rvalid_o, .s_axi_rready_i,
        .s_axi_rdata_o, .s_axi_rresp_o, .memory_monitor_node_i,
        .change_valid_i, .change_index_i, .watch_mask_o,
        .watched_change_o, .watched_index_o);

    always #5 sys_clk_i = ~sys_clk_i;

    // =========================================================
    // comparison and verdict
    // =========================================================
    task automatic check(input string nm, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // results are paired with the oldest note as they appear
    always @(posedge sys_clk_i) begin
        if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i) begin
            check("bresp", 64'(s_axi_bresp_o), 64'(exp_b.pop_front()));
        end
        if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i) begin
            e_r = exp_r.pop_front();
            check("rdata", 64'(s_axi_rdata_o), 64'(e_r[31:0]));
            check("rresp", 64'(s_axi_rresp_o), 64'(e_r[33:32]));
        end
        if (watched_change_o === 1'b1) begin
            check("hit expected", 64'(exp_h.size() > 0), 64'h1);
            if (exp_h.size() > 0) begin
                e_h = exp_h.pop_front();
                check("hit index", 64'(watched_index_o), 64'(e_h));
            end
        end
    end

    // =========================================================
    // bus and stimulus tasks
    // =========================================================
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] r);
        bit done;
        done = 0;
        exp_b.push_back(r);
        s_axi_awvalid_i <= 1'b1;
        s_axi_awaddr_i <= a;
        s_axi_wvalid_i <= 1'b1;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= s;
        s_axi_bready_i <= 1'b1;
        while (!done) begin
            @(posedge sys_clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            done = s_axi_bvalid_o === 1'b1;
        end
        s_axi_bready_i <= 1'b0;
        // one idle edge so a following call never re-drives bready now
        @(posedge sys_clk_i);
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        bit done;
        done = 0;
        exp_r.push_back({r, d});
        s_axi_arvalid_i <= 1'b1;
        s_axi_araddr_i <= a;
        s_axi_rready_i <= 1'b1;
        while (!done) begin
            @(posedge sys_clk_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            done = s_axi_rvalid_o === 1'b1;
        end
        s_axi_rready_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : axi_rd

    task automatic wr_mask(input bit hi, input logic [31:0] d,
                           input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) m[hi*32+b*8 +: 8] = d[b*8 +: 8];
        end
        axi_wr(hi ? BCWM_MASK_HI_OFFSET : BCWM_MASK_LO_OFFSET, d, s,
               BCWM_RESP_OKAY);
    endtask : wr_mask

    task automatic rd_mask();
        axi_rd(BCWM_MASK_LO_OFFSET, m[31:0], BCWM_RESP_OKAY);
        axi_rd(BCWM_MASK_HI_OFFSET, m[63:32], BCWM_RESP_OKAY);
        check("mask port", watch_mask_o, m);
    endtask : rd_mask

    // back-to-back change pulses over every block
    task automatic sweep(input logic mode);
        int n_hit;
        logic [31:0] st;
        n_hit = 0;
        // any write to the hit count clears it
        axi_wr(BCWM_HIT_COUNT_OFFSET, $urandom(), 4'hf, BCWM_RESP_OKAY);
        memory_monitor_node_i <= mode;
        for (int i = 0; i < 64; i++) begin
            change_valid_i <= 1'b1;
            change_index_i <= 6'(i);
            if (m[i]) begin
                exp_h.push_back(6'(i));
                n_hit++;
                last_idx = 6'(i);
                seen = 1'b1;
            end
            @(posedge sys_clk_i);
        end
        change_valid_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        check("hits left", 64'(exp_h.size()), 64'h0);
        st = 32'h0;
        st[BCWM_STATUS_INDEX_LSB +: 6] = last_idx;
        st[BCWM_STATUS_SEEN_BIT] = seen;
        st[BCWM_STATUS_MONITOR_BIT] = mode;
        axi_rd(BCWM_STATUS_OFFSET, st, BCWM_RESP_OKAY);
        axi_rd(BCWM_HIT_COUNT_OFFSET, 32'(n_hit), BCWM_RESP_OKAY);
    endtask : sweep

    // =========================================================
    // tests
    // =========================================================
    initial begin
        void'($urandom(28940));
        repeat (6) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        m = BCWM_MASK_RESET;
        rd_mask();
        $display("test reset values done");
        for (int k = 0; k < 6; k++) begin
            wr_mask(k[0], $urandom(), 4'($urandom()));
            wr_mask(~k[0], $urandom(), 4'hf);
            rd_mask();
        end
        $display("test mask access done");
        axi_wr(12'h500, $urandom(), 4'hf, BCWM_RESP_SLVERR);
        axi_rd(12'h500, 32'h0, BCWM_RESP_SLVERR);
        rd_mask();
        $display("test unmapped done");
        for (int k = 0; k < 4; k++) begin
            wr_mask(1'b0, k == 1 ? '1 : k == 2 ? '0 : $urandom(), 4'hf);
            wr_mask(1'b1, k == 1 ? '1 : k == 2 ? '0 : $urandom(), 4'hf);
            sweep(k[0]);
        end
        $display("test change gate done");
        srst_i <= 1'b1;
        // three edges: the mask drop is seen while reset still disables
        repeat (3) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        m = BCWM_MASK_RESET;
        last_idx = 6'h0;
        seen = 1'b0;
        rd_mask();
        sweep(1'b1);
        $display("test second reset done");
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        print_verdict();
    end
endmodule : tb_bcwm_watch_mask
